// file: ctm_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// program flash model: streams one instruction's bytes
// ****************************************************************
module ctm_flash_model (
  input  wire logic       mclk,
  input  wire logic       start,
  input  wire logic [7:0] b0,
  input  wire logic [7:0] b1,
  input  wire logic [7:0] b2,
  output logic            progValid,
  output logic [7:0]      progByte
);
  logic [1:0] idx_q = 2'h3;

  // one byte per clock; pointer parks at 3 once the stream ends
  always @(posedge mclk) begin
    if (start)
      idx_q <= 2'h0;
    else if (idx_q != 2'h3)
      idx_q <= idx_q + 2'h1;
  end

  // only the opcode is flagged; a spent stream shows inverted data
  assign progValid = (idx_q == 2'h0);
  assign progByte  = (idx_q == 2'h0) ? b0 : (idx_q == 2'h1) ? b1 : (idx_q == 2'h2) ? b2 : ~b2;
endmodule
`default_nettype wire

// file: ctm_instr_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctm_timing_map.vh"

// ****************************************************************
// timing checker for the instruction timing block
// ****************************************************************
module ctm_instr_chk (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  progValid,
  input wire logic [7:0]            progByte,
  input wire logic                  busy_q,
  input wire logic                  byteTake_q,
  input wire logic                  instrDone_q,
  input wire logic [7:0]            opcode_q,
  input wire logic [7:0]            operandA_q,
  input wire logic [`CTM_LEN_W-1:0] instrBytes_q,
  input wire logic [`CTM_CYC_W-1:0] instrCycles_q,
  input wire logic                  branchTaken_q,
  input wire logic                  flashRead_q,
  input wire logic                  flashWrite_q,
  input wire logic                  codeRead_q,
  input wire logic                  directIsSfr_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // an idle core must take the offered opcode at once
  a_opcode_take: assert property (!busy_q && progValid |=> byteTake_q && opcode_q == $past(progByte))
    else $error("opcode not taken when idle");
  a_busy_done: assert property ($fell(busy_q) |-> instrDone_q)
    else $error("busy ended without done");
  a_multi_busy: assert property (instrDone_q && instrCycles_q > 1 |-> $past(busy_q))
    else $error("multi-cycle op without busy");
  a_cycle_floor: assert property (instrDone_q |-> instrBytes_q != 0 && instrCycles_q >= instrBytes_q && instrCycles_q <= 8)
    else $error("cycles below byte count");
  a_taken_longer: assert property (instrDone_q && branchTaken_q |-> instrCycles_q > instrBytes_q)
    else $error("taken branch not longer");
  a_flash_read: assert property (flashRead_q |-> instrDone_q && instrCycles_q == 3)
    else $error("flash read timing");
  a_flash_write: assert property (flashWrite_q |-> instrDone_q && instrBytes_q == 1)
    else $error("flash write timing");
  a_code_move: assert property (codeRead_q |-> instrDone_q && instrCycles_q == 3)
    else $error("code move timing");
  a_sfr_split: assert property ($changed(operandA_q) |-> directIsSfr_q == operandA_q[7])
    else $error("sfr split wrong");

  cover property (flashRead_q);
  cover property (flashWrite_q);
  cover property (instrDone_q && branchTaken_q);
endmodule
`default_nettype wire

// file: ctm_instr_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "ctm_timing_map.vh"

// Overview of operation
// - durations counted only in system clocks
// - most instructions: cycles equal byte count
// - failed conditional branch ends one cycle sooner
// - external-space move goes to program flash
// - no external data or program bus
// - add family: register 1/1, direct/immediate 2/2, indirect 1/2
// - subtract_with_borrow direct: two bytes, two cycles
// - logic to accumulator: 1 cycle register, else 2
// - logic to direct: immediate 3/3, accumulator 2/2
// - accumulator-only ops one byte, one cycle
// - direct-to-direct and immediate-to-direct moves 3/3
// - indirect ram writes two cycles, 1 or 2 bytes
// - data_pointer immediate load three bytes, three cycles
// - code_byte_move via data_pointer: 1 byte, 3 cycles
// - branch offset signed, from next instruction address
// - direct 0x00-0x7F ram, 0x80-0xFF sfr

module ctm_instr_timing (
  input  wire                   mclk,
  input  wire                   sys_rst,
  input  wire                   progValid,
  input  wire [7:0]             progByte,
  input  wire [15:0]            instrAddr,
  input  wire                   condMet,
  output reg                    busy_q,
  output reg                    byteTake_q,
  output reg                    instrDone_q,
  output reg  [7:0]             opcode_q,
  output reg  [7:0]             operandA_q,
  output reg  [7:0]             operandB_q,
  output reg  [`CTM_LEN_W-1:0]  instrBytes_q,
  output reg  [`CTM_CYC_W-1:0]  instrCycles_q,
  output reg                    branchTaken_q,
  output reg  [15:0]            branchTarget_q,
  output reg                    flashRead_q,
  output reg                    flashWrite_q,
  output reg                    flashViaPointer_q,
  output reg                    codeRead_q,
  output reg                    directIsSfr_q
);

  // ****************************************************************
  // sequencer states, one-hot
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg  [`CTM_CYC_W-1:0] cnt_q;
  reg  [`CTM_CYC_W-1:0] cnt_d;
  reg  [15:0]           startAddr_q;

  wire                  inIdle = state_q[0];
  wire [7:0]            opSel  = inIdle ? progByte : opcode_q;
  wire [`CTM_LEN_W-1:0] lkBytes;
  wire [`CTM_CYC_W-1:0] lkCycles;
  wire                  lkCond;
  wire                  lkRel;

  ctm_op_timing uLookup (
    .opcode   (opSel),
    .opBytes  (lkBytes),
    .opCycles (lkCycles),
    .opCond   (lkCond),
    .opRel    (lkRel)
  );

  // ****************************************************************
  // effective length: a branch whose test fails drops its last cycle
  // ****************************************************************
  wire                  notTaken = lkCond & ~condMet;
  wire [`CTM_CYC_W-1:0] effCycles = lkCycles - {{(`CTM_CYC_W-1){1'b0}}, notTaken};
  wire                  startOp  = inIdle & progValid;
  wire                  lastCyc  = inIdle ? (startOp && effCycles == 4'd1)
                                          : (cnt_q + 4'd1 == effCycles);
  wire                  grabByte = ~inIdle && ({2'b00, lkBytes} > cnt_q);

  // the displacement is the last operand byte: live on the bus in the cycle
  // it arrives, otherwise taken from the register that captured it; a taken
  // branch can end a cycle after its last byte, so both sources are needed
  wire [7:0]  relLive  = (lkBytes == 2'd3) ? operandB_q : operandA_q;
  wire [7:0]  relByte  = ({2'b00, lkBytes} == cnt_q + 4'd1) ? progByte : relLive;
  // a one-cycle op ends on its opcode edge, before startAddr_q is loaded
  wire [15:0] baseAddr = inIdle ? instrAddr : startAddr_q;
  wire [15:0] nextAddr = baseAddr + {14'h0000, lkBytes};
  wire [15:0] relTgt   = nextAddr + {{8{relByte[7]}}, relByte};

  // ****************************************************************
  // next state: one clock per cycle count, nothing grouped
  // ****************************************************************
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'd1;
        if (startOp && !lastCyc) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q + 4'd1;
        if (lastCyc) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers and registered outputs
  // ****************************************************************
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q           <= ST_IDLE;
      cnt_q             <= 4'd0;
      startAddr_q       <= 16'h0000;
      busy_q            <= 1'b0;
      byteTake_q        <= 1'b0;
      instrDone_q       <= 1'b0;
      opcode_q          <= 8'h00;
      operandA_q        <= 8'h00;
      operandB_q        <= 8'h00;
      instrBytes_q      <= 2'd0;
      instrCycles_q     <= 4'd0;
      branchTaken_q     <= 1'b0;
      branchTarget_q    <= 16'h0000;
      flashRead_q       <= 1'b0;
      flashWrite_q      <= 1'b0;
      flashViaPointer_q <= 1'b0;
      codeRead_q        <= 1'b0;
      directIsSfr_q     <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      busy_q       <= state_d[1];
      byteTake_q   <= startOp | grabByte;
      instrDone_q  <= lastCyc;
      flashRead_q  <= 1'b0;
      flashWrite_q <= 1'b0;
      codeRead_q   <= 1'b0;
      if (startOp) begin
        opcode_q    <= progByte;
        startAddr_q <= instrAddr;
      end
      // operand bytes arrive one per cycle behind the opcode
      if (grabByte && cnt_q == 4'd1) begin
        operandA_q    <= progByte;
        directIsSfr_q <= (progByte >= `CTM_SFR_BASE);
      end
      if (grabByte && cnt_q == 4'd2) begin
        operandB_q <= progByte;
      end
      if (lastCyc) begin
        instrBytes_q   <= lkBytes;
        instrCycles_q  <= effCycles;
        branchTaken_q  <= lkRel & ~notTaken;
        // a branch that fails falls through to the next instruction
        branchTarget_q <= (lkRel & ~notTaken) ? relTgt : nextAddr;
        // no off-chip bus exists, so these always hit on-chip flash
        case (opSel)
          `CTM_OP_XRD_DATA_POINTER, `CTM_OP_XRD_R0, `CTM_OP_XRD_R1: begin
            flashRead_q       <= 1'b1;
            flashViaPointer_q <= (opSel == `CTM_OP_XRD_DATA_POINTER);
          end
          `CTM_OP_XWR_DATA_POINTER, `CTM_OP_XWR_R0, `CTM_OP_XWR_R1: begin
            flashWrite_q      <= 1'b1;
            flashViaPointer_q <= (opSel == `CTM_OP_XWR_DATA_POINTER);
          end
          `CTM_OP_CODE_DATA_POINTER, `CTM_OP_CODE_PC: begin
            codeRead_q        <= 1'b1;
            flashViaPointer_q <= (opSel == `CTM_OP_CODE_DATA_POINTER);
          end
          default: begin
            flashViaPointer_q <= flashViaPointer_q;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: ctm_op_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "ctm_timing_map.vh"

module ctm_op_timing (
  input  wire [7:0]              opcode,
  output reg  [`CTM_LEN_W-1:0]   opBytes,
  output reg  [`CTM_CYC_W-1:0]   opCycles,
  output reg                     opCond,
  output reg                     opRel
);

  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];
  wire       isRn  = opcode[3];
  wire       isRi  = (lo[3:1] == 3'b011);

  // ****************************************************************
  // byte length and clock count per opcode; cycles of a conditional
  // branch are the taken figure, the caller trims one when it fails
  // ****************************************************************
  always @* begin
    opBytes  = 2'd1;
    opCycles = 4'd1;
    opCond   = 1'b0;
    opRel    = 1'b0;
    // add, add_with_carry, subtract_with_borrow
    if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && lo >= 4'h4) begin
      if (isRn) begin
        opBytes = 2'd1; opCycles = 4'd1;
      end else if (isRi) begin
        opBytes = 2'd1; opCycles = 4'd2;
      end else begin
        opBytes = 2'd2; opCycles = 4'd2;
      end
    // logical_and_op, logical_or_op, logical_xor_op
    end else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo >= 4'h2) begin
      if (lo == 4'h3) begin
        opBytes = 2'd3; opCycles = 4'd3;
      end else if (lo == 4'h2) begin
        opBytes = 2'd2; opCycles = 4'd2;
      end else if (isRn) begin
        opBytes = 2'd1; opCycles = 4'd1;
      end else if (isRi) begin
        opBytes = 2'd1; opCycles = 4'd2;
      end else begin
        opBytes = 2'd2; opCycles = 4'd2;
      end
    // increment and decrement
    end else if ((hi == 4'h0 || hi == 4'h1) && lo >= 4'h4) begin
      if (lo == 4'h5) begin
        opBytes = 2'd2; opCycles = 4'd2;
      end else if (isRi) begin
        opCycles = 4'd2;
      end
    // conditional branches on carry or accumulator
    end else if ((hi >= 4'h4 && hi <= 4'h7) && lo == 4'h0) begin
      opBytes = 2'd2; opCycles = 4'd3; opCond = 1'b1; opRel = 1'b1;
    // bit test branches
    end else if ((hi >= 4'h1 && hi <= 4'h3) && lo == 4'h0) begin
      opBytes = 2'd3; opCycles = 4'd4; opCond = 1'b1; opRel = 1'b1;
    // compare and jump if not equal
    end else if (hi == 4'hB && lo >= 4'h4) begin
      opBytes = 2'd3; opCond = 1'b1; opRel = 1'b1;
      opCycles = isRi ? 4'd5 : 4'd4;
    // decrement and jump if not zero
    end else if (hi == 4'hD && (isRn || lo == 4'h5)) begin
      opCond = 1'b1; opRel = 1'b1;
      opBytes  = isRn ? 2'd2 : 2'd3;
      opCycles = isRn ? 4'd3 : 4'd4;
    end else begin
      case (opcode)
        8'h74, 8'hE5, 8'hF5, 8'h76, 8'h77, 8'hA6, 8'hA7: begin
          opBytes = 2'd2; opCycles = 4'd2;
        end
        8'h75, 8'h85, `CTM_OP_LOAD_DATA_POINTER: begin
          opBytes = 2'd3; opCycles = 4'd3;
        end
        8'hE6, 8'hE7, 8'hF6, 8'hF7: begin
          opCycles = 4'd2;
        end
        8'h86, 8'h87: begin
          opBytes = 2'd2; opCycles = 4'd2;
        end
        `CTM_OP_CODE_DATA_POINTER, `CTM_OP_CODE_PC,
        `CTM_OP_XRD_DATA_POINTER, `CTM_OP_XRD_R0, `CTM_OP_XRD_R1,
        `CTM_OP_XWR_DATA_POINTER, `CTM_OP_XWR_R0, `CTM_OP_XWR_R1: begin
          opCycles = 4'd3;
        end
        8'hA4: opCycles = 4'd4;                    // multiply
        8'h84: opCycles = 4'd8;                    // divide
        8'h80: begin
          opBytes = 2'd2; opCycles = 4'd3; opRel = 1'b1;
        end
        default: begin
          // accumulator-only ops and the rest: one byte, one cycle, except register moves with an immediate or direct operand: 2/2
          if (hi >= 4'h7 && hi != 4'hB && isRn) begin
            opBytes = (hi == 4'h7 || hi == 4'hA) ? 2'd2 : 2'd1;
            opCycles = (hi == 4'h7 || hi == 4'hA || hi == 4'h8) ? 4'd2 : 4'd1;
            if (hi == 4'h8) opBytes = 2'd2;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: ctm_timing_map.vh
`ifndef CTM_TIMING_MAP_VH
`define CTM_TIMING_MAP_VH

// ****************************************************************
// widths
// ****************************************************************
`define CTM_LEN_W        2
`define CTM_CYC_W        4

// ****************************************************************
// direct address split: low half is data ram, high half is sfr space
// ****************************************************************
`define CTM_SFR_BASE     8'h80

// ****************************************************************
// external-space move opcodes (all land on program flash here)
// ****************************************************************
`define CTM_OP_XRD_DATA_POINTER  8'hE0
`define CTM_OP_XRD_R0    8'hE2
`define CTM_OP_XRD_R1    8'hE3
`define CTM_OP_XWR_DATA_POINTER  8'hF0
`define CTM_OP_XWR_R0    8'hF2
`define CTM_OP_XWR_R1    8'hF3

// ****************************************************************
// code byte moves and data pointer load
// ****************************************************************
`define CTM_OP_CODE_DATA_POINTER 8'h93
`define CTM_OP_CODE_PC   8'h83
`define CTM_OP_LOAD_DATA_POINTER 8'h90

`endif

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctm_timing_map.vh"

module tb;
  logic mclk = 1'b0, sys_rst = 1'b1, start = 1'b0, condMet = 1'b0;
  logic progValid, busy_q, byteTake_q, instrDone_q, branchTaken_q;
  logic flashRead_q, flashWrite_q, flashViaPointer_q, codeRead_q, directIsSfr_q;
  logic [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00;
  logic [7:0] progByte, opcode_q, operandA_q, operandB_q;
  logic [15:0] instrAddr = 16'h1000, branchTarget_q;
  logic [`CTM_LEN_W-1:0] instrBytes_q;
  logic [`CTM_CYC_W-1:0] instrCycles_q;
  int error_cnt = 0, check_count = 0;

  ctm_instr_timing i_ctm_instr_timing (.mclk, .sys_rst, .progValid, .progByte, .instrAddr,
    .condMet, .busy_q, .byteTake_q, .instrDone_q, .opcode_q, .operandA_q, .operandB_q,
    .instrBytes_q, .instrCycles_q, .branchTaken_q, .branchTarget_q, .flashRead_q,
    .flashWrite_q, .flashViaPointer_q, .codeRead_q, .directIsSfr_q);
  ctm_flash_model i_ctm_flash_model (.mclk, .start, .b0, .b1, .b2, .progValid, .progByte);

  // free-running 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  // issue one instruction and count clocks until done
  task automatic run_op(input logic [7:0] op, a, b, input logic [3:0] eb, ec, input logic c);
    int n;
    @(posedge mclk);
    b0 <= op;
    b1 <= a;
    b2 <= b;
    condMet <= c;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      #1;
    end while (instrDone_q !== 1'b1 && n < 12);
    chk(n == ec && instrCycles_q === ec && instrBytes_q === eb[1:0], "timing");
  endtask

  task automatic t_arith();
    logic [15:0] t [10] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811, 16'h3522,
                            16'h3612, 16'h9522, 16'h9612, 16'h9422};
    for (int i = 0; i < 10; i++)
      run_op(t[i][15:8], 8'h12, 8'h34, t[i][7:4], t[i][3:0], 1'b0);
    $display("test arith done");
  endtask

  task automatic t_logic();
    logic [15:0] t [14] = '{16'h5811, 16'h5612, 16'h4422, 16'h6522, 16'h5333, 16'h4222,
                            16'h6333, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311,
                            16'h1311, 16'hC411};
    for (int i = 0; i < 14; i++)
      run_op(t[i][15:8], 8'h12, 8'h34, t[i][7:4], t[i][3:0], 1'b0);
    $display("test logic done");
  endtask

  task automatic t_move();
    logic [15:0] t [6] = '{16'h8533, 16'h7533, 16'hF612, 16'hA622, 16'h7622, 16'h9033};
    for (int i = 0; i < 6; i++)
      run_op(t[i][15:8], 8'h21, 8'h43, t[i][7:4], t[i][3:0], 1'b0);
    chk(operandA_q === 8'h21 && operandB_q === 8'h43, "operands");
    run_op(8'h93, 8'h00, 8'h00, 4'h1, 4'h3, 1'b0);
    chk(codeRead_q === 1'b1 && flashViaPointer_q === 1'b1, "code move");
    $display("test move done");
  endtask

  task automatic t_ext();
    logic [7:0] t [4] = '{8'hE0, 8'hE2, 8'hF0, 8'hF2};
    for (int i = 0; i < 4; i++) begin
      run_op(t[i], 8'h00, 8'h00, 4'h1, 4'h3, 1'b0);
      chk(flashRead_q === ~t[i][4] && flashWrite_q === t[i][4], "flash dir");
      chk(flashViaPointer_q === ~t[i][1], "flash pointer");
    end
    $display("test ext done");
  endtask

  task automatic t_branch();
    run_op(8'h60, 8'hFE, 8'h00, 4'h2, 4'h2, 1'b0);
    chk(branchTaken_q === 1'b0 && branchTarget_q === 16'h1002, "not taken");
    run_op(8'h60, 8'hFE, 8'h00, 4'h2, 4'h3, 1'b1);
    chk(branchTaken_q === 1'b1 && branchTarget_q === 16'h1000, "taken");
    $display("test branch done");
  endtask

  task automatic t_sfr();
    run_op(8'h25, 8'h7F, 8'h00, 4'h2, 4'h2, 1'b0);
    chk(directIsSfr_q === 1'b0, "ram side");
    run_op(8'h25, 8'h80, 8'h00, 4'h2, 4'h2, 1'b0);
    chk(directIsSfr_q === 1'b1, "sfr side");
    $display("test sfr done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 1000 clocks
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(busy_q === 1'b0 && instrDone_q === 1'b0, "reset state");
    t_arith();
    t_logic();
    t_move();
    t_ext();
    t_branch();
    t_sfr();
    print_verdict();
  end
endmodule

bind ctm_instr_timing ctm_instr_chk i_chk (.mclk, .sys_rst, .progValid, .progByte, .busy_q,
  .byteTake_q, .instrDone_q, .opcode_q, .operandA_q, .instrBytes_q, .instrCycles_q,
  .branchTaken_q, .flashRead_q, .flashWrite_q, .codeRead_q, .directIsSfr_q);
`default_nettype wire
